// ==== rtl/vlcis_pkg.sv ====
/*
 * constants and carrier types shared by the label capture top and its
 * two-wire slave.
 * assumes: included before any file that names vlcis_pkg.
 */
package vlcis_pkg;

	// ==================================================================
	// two-wire addressing and control register
	localparam logic [6:0] ADDR_BASE     = 7'h10;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam int         CTRL_FMT_BIT  = 0;
	localparam int         CTRL_MODE_BIT = 1;
	localparam int         CTRL_HDR_BIT  = 2;

	// ==================================================================
	// transfer register
	localparam int         NUM_BYTES     = 13;
	localparam logic [7:0] FILL_BYTE     = 8'hFF;

	// ==================================================================
	// byte numbers within a received line, first word is byte 1
	localparam logic [5:0] NIC_FIRST     = 6'h0D;
	localparam logic [5:0] UDT_FIRST     = 6'h0F;
	localparam logic [5:0] UDT_LAST      = 6'h15;
	localparam logic [5:0] SPL_FIRST     = 6'h16;
	localparam logic [5:0] SPL_LAST      = 6'h19;
	localparam logic [5:0] FMT2_FIRST    = 6'h0D;
	localparam logic [5:0] FMT2_LAST     = 6'h19;
	localparam logic [5:0] HDR_FIRST     = 6'h26;
	localparam logic [5:0] HDR_LAST      = 6'h2D;
	localparam logic [5:0] L16_FIRST     = 6'h03;
	localparam logic [5:0] L16_LAST      = 6'h0F;
	localparam logic [3:0] SLOT_NIC      = 4'h7;
	localparam logic [3:0] SLOT_SPL      = 4'h9;

	// ==================================================================
	// line clock rates the pll is steered to
	localparam int         SYSCLK_L16_HZ = 10_000_000;
	localparam int         SYSCLK_TT_HZ  = 13_875_000;

	// ==================================================================
	// types
	typedef enum logic [1:0] {
		VLCIS_KIND_L16,
		VLCIS_KIND_FMT1,
		VLCIS_KIND_FMT2,
		VLCIS_KIND_HDR
	} vlcis_kind_t;

	typedef enum logic [2:0] {
		VLCIS_ST_IDLE,
		VLCIS_ST_ADDR,
		VLCIS_ST_ADDR_ACK,
		VLCIS_ST_WR_DATA,
		VLCIS_ST_WR_ACK,
		VLCIS_ST_RD_DATA,
		VLCIS_ST_RD_ACK,
		VLCIS_ST_WAIT_STOP
	} vlcis_i2c_st_t;

	typedef struct packed {
		logic        sof;
		logic        eol;
		logic        word_valid;
		vlcis_kind_t kind;
		logic [15:0] word;
	} vlcis_line_t;

	typedef logic [NUM_BYTES-1:0][7:0] vlcis_bytes_t;

endpackage

// ==== rtl/vlcis_i2c_slave.sv ====
/*
 * two-wire slave: one control byte in, read bytes out for as long as the master acks.
 * assumes: scl and sda arrive asynchronously from the bus pins; the
 * read byte for o_rd_idx is supplied combinationally by the parent.
 */
`timescale 1ns/1ns

module vlcis_i2c_slave (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       i_addr_sel,
	input  wire logic [7:0] i_rd_byte,
	output logic            o_sda_out,
	output logic            o_sda_oe,
	output logic [3:0]      o_rd_idx,
	output logic            o_wr_stb,
	output logic [7:0]      o_wr_byte,
	output logic            o_busy
);

	// ==================================================================
	// state
	typedef struct packed {
		logic [2:0]              scl_s;
		logic [2:0]              sda_s;
		logic                    scl;
		logic                    sda;
		vlcis_pkg::vlcis_i2c_st_t st;
		logic [3:0]              bits;
		logic [7:0]              shreg;
		logic                    rw;
		logic                    mack;
		logic [3:0]              idx;
		logic                    oe;
		logic                    wr_stb;
		logic [7:0]              wr_byte;
	} vlcis_i2c_state_t;

	vlcis_i2c_state_t r;
	vlcis_i2c_state_t n;
	logic             rise;
	logic             fall;
	logic             start;
	logic             stop;

	// ==================================================================
	// next state
	always_comb begin
		n = r;
		n.wr_stb = 1'b0;
		// only the agreed samples are used, never the first flop
		n.scl_s = {r.scl_s[1:0], i_scl};
		n.sda_s = {r.sda_s[1:0], i_sda};
		if (r.scl_s[1] == r.scl_s[2]) begin
			n.scl = r.scl_s[2];
		end
		if (r.sda_s[1] == r.sda_s[2]) begin
			n.sda = r.sda_s[2];
		end
		rise  = !r.scl && n.scl;
		fall  = r.scl && !n.scl;
		start = r.scl && n.scl && r.sda && !n.sda;
		stop  = r.scl && n.scl && !r.sda && n.sda;
		if (start) begin
			n.st   = vlcis_pkg::VLCIS_ST_ADDR;
			n.bits = 4'h0;
			n.idx  = 4'h0;
			n.oe   = 1'b0;
		end else if (stop) begin
			n.st = vlcis_pkg::VLCIS_ST_IDLE;
			n.oe = 1'b0;
		end else begin
			// sda is only moved on a falling scl edge
			case (r.st)
			vlcis_pkg::VLCIS_ST_ADDR: begin
				if (rise) begin
					n.shreg = {r.shreg[6:0], n.sda};
					n.bits  = r.bits + 4'h1;
				end else if (fall && r.bits == 4'h8) begin
					n.bits = 4'h0;
					if (r.shreg[7:1] ==
					    {vlcis_pkg::ADDR_BASE[6:1], i_addr_sel}) begin
						n.oe = 1'b1;
						n.rw = r.shreg[0];
						n.st = vlcis_pkg::VLCIS_ST_ADDR_ACK;
					end else begin
						n.st = vlcis_pkg::VLCIS_ST_WAIT_STOP;
					end
				end
			end
			vlcis_pkg::VLCIS_ST_ADDR_ACK: begin
				if (fall) begin
					n.bits = 4'h0;
					if (r.rw) begin
						n.shreg = i_rd_byte;
						n.oe    = !i_rd_byte[7];
						n.st    = vlcis_pkg::VLCIS_ST_RD_DATA;
					end else begin
						n.oe = 1'b0;
						n.st = vlcis_pkg::VLCIS_ST_WR_DATA;
					end
				end
			end
			vlcis_pkg::VLCIS_ST_WR_DATA: begin
				if (rise) begin
					n.shreg = {r.shreg[6:0], n.sda};
					n.bits  = r.bits + 4'h1;
				end else if (fall && r.bits == 4'h8) begin
					n.wr_byte = r.shreg;
					n.wr_stb  = 1'b1;
					n.oe      = 1'b1;
					n.st      = vlcis_pkg::VLCIS_ST_WR_ACK;
				end
			end
			vlcis_pkg::VLCIS_ST_WR_ACK: begin
				// further bytes are left unacknowledged
				if (fall) begin
					n.oe = 1'b0;
					n.st = vlcis_pkg::VLCIS_ST_WAIT_STOP;
				end
			end
			vlcis_pkg::VLCIS_ST_RD_DATA: begin
				if (fall) begin
					n.bits = r.bits + 4'h1;
					if (r.bits == 4'h7) begin
						n.oe = 1'b0;
						n.st = vlcis_pkg::VLCIS_ST_RD_ACK;
					end else begin
						n.shreg = {r.shreg[6:0], 1'b1};
						n.oe    = !r.shreg[6];
					end
				end
			end
			vlcis_pkg::VLCIS_ST_RD_ACK: begin
				if (rise) begin
					n.mack = !n.sda;
					if (!n.sda && r.idx != 4'hF) begin
						n.idx = r.idx + 4'h1;
					end
				end else if (fall) begin
					n.bits = 4'h0;
					if (r.mack) begin
						n.shreg = i_rd_byte;
						n.oe    = !i_rd_byte[7];
						n.st    = vlcis_pkg::VLCIS_ST_RD_DATA;
					end else begin
						n.st = vlcis_pkg::VLCIS_ST_WAIT_STOP;
					end
				end
			end
			vlcis_pkg::VLCIS_ST_WAIT_STOP: begin
				n.oe = 1'b0;
			end
			default: begin
				n.st = vlcis_pkg::VLCIS_ST_IDLE;
				n.oe = 1'b0;
			end
			endcase
		end
	end

	// ==================================================================
	// registers
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			r       <= '0;
			r.scl_s <= 3'h7;
			r.sda_s <= 3'h7;
			r.scl   <= 1'b1;
			r.sda   <= 1'b1;
			r.st    <= vlcis_pkg::VLCIS_ST_IDLE;
		end else begin
			r <= n;
		end
	end

	// ==================================================================
	// outputs; scl is never driven, so no stretching
	assign o_sda_out = 1'b0;
	assign o_sda_oe  = r.oe;
	assign o_rd_idx  = r.idx;
	assign o_wr_stb  = r.wr_stb;
	assign o_wr_byte = r.wr_byte;
	assign o_busy    = (r.st != vlcis_pkg::VLCIS_ST_IDLE);

endmodule // vlcis_i2c_slave

// ==== rtl/vlcis_top.sv ====
/*
 * label capture core: line capture on the line clock, transfer register,
 * control register and status pins on the core clock.
 * assumes: a slicer delivers words on i_line_clk framed by sof/eol; the
 * line clock may stop between lines; i_rst_n is seen by both clocks.
 */
// Summary of operation
// - address pair 20h/21h, or 22h/23h when select pin is high.
// - master sends eight address bits; device pulls sda low on ninth.
// - write carries one byte; device acks it and loads control register.
// - sda changes only while scl is low, except start and stop.
// - only master drives scl; device drives sda only to ack or send.
// - control register picks teletext packet mode or line-16 mode.
// - format 1 packet bytes stored exactly as received.
// - format 2 bytes hamming checked, single errors corrected.
// - clean or corrected format 2 data latched drives data valid low.
// - line-16 bits biphase checked; any error discards the line.
// - clean line-16 transfer marked by data valid going low.
// - transfer register refreshed per line, frozen during bus access.
// - format 2 takes packet bytes 13 to 25.
// - format 1 takes network id 13-14, date 15-21, label 22-25.
// - header time capture takes header bytes 38 to 45.
// - line clock 10 MHz in line-16 mode, 13.875 MHz in teletext.
// - first field flag high during first field, low otherwise.
// - test pin high enters test mode, low is normal operation.
// - control bit 1 picks mode; all bits reset to zero.
// - bit 0 picks format 2 or other; bit 2 format 1 or header.
// - read pointer cleared at start, steps on master ack, 13 bytes.
`timescale 1ns/1ns

module vlcis_top (
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_line_clk,
	input  wire vlcis_pkg::vlcis_line_t i_line,
	input  wire logic                   i_scl,
	input  wire logic                   i_sda,
	output logic                        o_sda_out,
	output logic                        o_sda_oe,
	input  wire logic                   i_address_select_pin,
	input  wire logic                   i_test_mode_pin,
	input  wire logic                   i_field_first,
	output logic                        o_data_valid_n,
	output logic                        o_first_field_flag,
	output logic                        o_teletext_label_mode,
	output logic [7:0]                  o_ctrl
);

	// ==================================================================
	// decode helpers
	// returns {double error, data nibble}; odd parity per check group
	function automatic logic [4:0] vlcis_ham84(input logic [7:0] b);
		logic [2:0] f;
		logic [3:0] d;
		logic       err;
		f   = {~(b[1] ^ b[3] ^ b[4] ^ b[5]),
		       ~(b[1] ^ b[2] ^ b[3] ^ b[7]),
		       ~(b[0] ^ b[1] ^ b[5] ^ b[7])};
		d   = {b[7], b[5], b[3], b[1]};
		err = 1'b0;
		if (^b) begin
			err = (f != 3'h0);
		end else begin
			case (f)
			3'h7:    d[0] = ~d[0];
			3'h6:    d[1] = ~d[1];
			3'h5:    d[2] = ~d[2];
			3'h3:    d[3] = ~d[3];
			default: d = d;
			endcase
		end
		return {err, d};
	endfunction

	// returns {coding error, byte}; each bit cell must hold a transition
	function automatic logic [8:0] vlcis_biphase(input logic [15:0] w);
		logic [7:0] v;
		logic       err;
		v   = 8'h00;
		err = 1'b0;
		for (int i = 0; i < 8; i++) begin
			v[i] = w[2*i+1];
			if (w[2*i+1] == w[2*i]) begin
				err = 1'b1;
			end
		end
		return {err, v};
	endfunction

	// returns {hit, slot, high nibble} for byte number n of a line kind
	function automatic logic [5:0] vlcis_slot(
		input vlcis_pkg::vlcis_kind_t k,
		input logic [5:0]             num
	);
		logic [5:0] off;
		logic [5:0] res;
		off = 6'h00;
		res = 6'h00;
		case (k)
		vlcis_pkg::VLCIS_KIND_FMT1: begin
			if (num >= vlcis_pkg::UDT_FIRST && num <= vlcis_pkg::UDT_LAST) begin
				off = num - vlcis_pkg::UDT_FIRST;
				res = {1'b1, off[3:0], 1'b0};
			end else if (num >= vlcis_pkg::SPL_FIRST &&
			             num <= vlcis_pkg::SPL_LAST) begin
				off = num - vlcis_pkg::SPL_FIRST;
				res = {1'b1, off[3:0] + vlcis_pkg::SLOT_SPL, 1'b0};
			end else if (num >= vlcis_pkg::NIC_FIRST &&
			             num < vlcis_pkg::UDT_FIRST) begin
				off = num - vlcis_pkg::NIC_FIRST;
				res = {1'b1, off[3:0] + vlcis_pkg::SLOT_NIC, 1'b0};
			end
		end
		vlcis_pkg::VLCIS_KIND_FMT2: begin
			if (num >= vlcis_pkg::FMT2_FIRST && num <= vlcis_pkg::FMT2_LAST) begin
				off = num - vlcis_pkg::FMT2_FIRST;
				res = {1'b1, off[4:1], ~off[0]};
			end
		end
		vlcis_pkg::VLCIS_KIND_HDR: begin
			if (num >= vlcis_pkg::HDR_FIRST && num <= vlcis_pkg::HDR_LAST) begin
				off = num - vlcis_pkg::HDR_FIRST;
				res = {1'b1, off[3:0], 1'b0};
			end
		end
		default: begin
			if (num >= vlcis_pkg::L16_FIRST && num <= vlcis_pkg::L16_LAST) begin
				off = num - vlcis_pkg::L16_FIRST;
				res = {1'b1, off[3:0], 1'b0};
			end
		end
		endcase
		return res;
	endfunction

	// ==================================================================
	// line clock domain state
	typedef struct packed {
		logic [7:0]             ctrl_s1;
		logic [7:0]             ctrl_s2;
		logic [7:0]             ctrl_s3;
		logic [7:0]             ctrl_f;
		logic [2:0]             ack_s;
		logic                   ack_f;
		logic                   act;
		vlcis_pkg::vlcis_kind_t kind;
		logic [5:0]             cnt;
		logic                   bad;
		vlcis_pkg::vlcis_bytes_t cap;
		vlcis_pkg::vlcis_bytes_t hold;
		logic                   req;
	} vlcis_link_state_t;

	// ==================================================================
	// core clock domain state
	typedef struct packed {
		logic [2:0]             req_s;
		logic                   req_f;
		logic                   ack;
		logic [7:0]             ctrl;
		vlcis_pkg::vlcis_bytes_t xfer;
		logic                   data_valid_n;
		logic [2:0]             fld_s;
		logic                   fld;
		logic [2:0]             tst_s;
		logic                   tst;
		logic [2:0]             sel_s;
		logic                   sel;
		logic                   dv_out;
		logic                   ff_out;
	} vlcis_core_state_t;

	vlcis_link_state_t l;
	vlcis_link_state_t ln;
	vlcis_core_state_t c;
	vlcis_core_state_t cn;
	logic              busy;
	logic              wr_stb;
	logic [7:0]        wr_byte;
	logic [3:0]        rd_idx;
	logic [7:0]        rd_byte;
	logic              want;
	logic [5:0]        num;
	logic [5:0]        slot;
	logic [4:0]        ham;
	logic [8:0]        bph;

	// ==================================================================
	// line capture
	always_comb begin
		ln = l;
		// control bits are quasi static; ack is a toggle
		ln.ctrl_s1 = c.ctrl;
		ln.ctrl_s2 = l.ctrl_s1;
		ln.ctrl_s3 = l.ctrl_s2;
		if (l.ctrl_s2 == l.ctrl_s3) begin
			ln.ctrl_f = l.ctrl_s3;
		end
		ln.ack_s = {l.ack_s[1:0], c.ack};
		if (l.ack_s[1] == l.ack_s[2]) begin
			ln.ack_f = l.ack_s[2];
		end
		if (!l.ctrl_f[vlcis_pkg::CTRL_MODE_BIT]) begin
			want = (l.kind == vlcis_pkg::VLCIS_KIND_L16);
		end else if (!l.ctrl_f[vlcis_pkg::CTRL_FMT_BIT]) begin
			want = (l.kind == vlcis_pkg::VLCIS_KIND_FMT2);
		end else if (!l.ctrl_f[vlcis_pkg::CTRL_HDR_BIT]) begin
			want = (l.kind == vlcis_pkg::VLCIS_KIND_FMT1);
		end else begin
			want = (l.kind == vlcis_pkg::VLCIS_KIND_HDR);
		end
		num  = (l.cnt == 6'h3F) ? l.cnt : l.cnt + 6'h01;
		slot = vlcis_slot(l.kind, num);
		ham  = vlcis_ham84(i_line.word[7:0]);
		bph  = vlcis_biphase(i_line.word);
		if (i_line.sof) begin
			ln.act  = 1'b1;
			ln.kind = i_line.kind;
			ln.cnt  = 6'h00;
			ln.bad  = 1'b0;
			ln.cap  = {vlcis_pkg::NUM_BYTES{vlcis_pkg::FILL_BYTE}};
		end else if (i_line.word_valid && l.act) begin
			ln.cnt = num;
			case (l.kind)
			vlcis_pkg::VLCIS_KIND_L16: begin
				if (bph[8]) begin
					ln.bad = 1'b1;
				end
				if (slot[5]) begin
					ln.cap[slot[4:1]] = bph[7:0];
				end
			end
			vlcis_pkg::VLCIS_KIND_FMT2: begin
				if (slot[5] && ham[4]) begin
					ln.bad = 1'b1;
				end
				if (slot[5] && slot[0]) begin
					ln.cap[slot[4:1]][7:4] = ham[3:0];
				end else if (slot[5]) begin
					ln.cap[slot[4:1]][3:0] = ham[3:0];
				end
			end
			default: begin
				if (slot[5]) begin
					ln.cap[slot[4:1]] = i_line.word[7:0];
				end
			end
			endcase
		end else if (i_line.eol && l.act) begin
			ln.act = 1'b0;
			// a line is dropped while the previous one is still unclaimed
			if (want && !l.bad && (l.req == l.ack_f)) begin
				ln.hold = l.cap;
				ln.req  = !l.req;
			end
		end
	end

	always_ff @(posedge i_line_clk) begin
		if (!i_rst_n) begin
			l <= '0;
		end else begin
			l <= ln;
		end
	end

	// ==================================================================
	// two-wire slave
	assign rd_byte = (rd_idx < 4'(vlcis_pkg::NUM_BYTES)) ?
	                 c.xfer[rd_idx] : vlcis_pkg::FILL_BYTE;

	vlcis_i2c_slave u_slave (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.i_addr_sel (c.sel),
		.i_rd_byte  (rd_byte),
		.o_sda_out  (o_sda_out),
		.o_sda_oe   (o_sda_oe),
		.o_rd_idx   (rd_idx),
		.o_wr_stb   (wr_stb),
		.o_wr_byte  (wr_byte),
		.o_busy     (busy)
	);

	// ==================================================================
	// transfer register, control register, status pins
	always_comb begin
		cn = c;
		cn.req_s = {c.req_s[1:0], l.req};
		cn.fld_s = {c.fld_s[1:0], i_field_first};
		cn.tst_s = {c.tst_s[1:0], i_test_mode_pin};
		cn.sel_s = {c.sel_s[1:0], i_address_select_pin};
		if (c.req_s[1] == c.req_s[2]) begin
			cn.req_f = c.req_s[2];
		end
		if (c.fld_s[1] == c.fld_s[2]) begin
			cn.fld = c.fld_s[2];
		end
		if (c.tst_s[1] == c.tst_s[2]) begin
			cn.tst = c.tst_s[2];
		end
		if (c.sel_s[1] == c.sel_s[2]) begin
			cn.sel = c.sel_s[2];
		end
		if (wr_stb) begin
			cn.ctrl = wr_byte;
		end
		// new field releases data valid
		if (cn.fld != c.fld) begin
			cn.data_valid_n = 1'b1;
		end
		// hold is stable until acked; a busy bus drops the line
		if (c.req_f != c.ack) begin
			cn.ack = c.req_f;
			if (!busy) begin
				cn.xfer = l.hold;
				cn.data_valid_n = 1'b0;
			end
		end
		cn.dv_out = cn.tst ? cn.sel : cn.data_valid_n;
		cn.ff_out = cn.tst ? cn.sel : cn.fld;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			c        <= '0;
			c.ctrl   <= vlcis_pkg::CTRL_RESET;
			c.xfer   <= {vlcis_pkg::NUM_BYTES{vlcis_pkg::FILL_BYTE}};
			c.data_valid_n   <= 1'b1;
			c.dv_out <= 1'b1;
		end else begin
			c <= cn;
		end
	end

	// ==================================================================
	// outputs; mode also steers the pll rate
	assign o_data_valid_n        = c.dv_out;
	assign o_first_field_flag    = c.ff_out;
	assign o_teletext_label_mode = c.ctrl[vlcis_pkg::CTRL_MODE_BIT];
	assign o_ctrl                = c.ctrl;

endmodule // vlcis_top

// ==== verification/vlcis_top_checker.sv ====
/*
 * checker for the label capture top: bus pin, control and status pins.
 * assumes: bound onto vlcis_top; only the core clock domain is watched.
 */
`timescale 1ns/1ns

module vlcis_top_checker (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_scl,
	input  wire logic       o_sda_out,
	input  wire logic       o_sda_oe,
	input  wire logic       i_address_select_pin,
	input  wire logic       i_test_mode_pin,
	input  wire logic       i_field_first,
	input  wire logic       o_data_valid_n,
	input  wire logic       o_first_field_flag,
	input  wire logic       o_teletext_label_mode,
	input  wire logic [7:0] o_ctrl
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	// ==================================================
	// assertions
	chk_sda_never_high: assert property (
		o_sda_out == 1'b0) else $error("sda driven high");
	chk_reset_values: assert property (
		$rose(i_rst_n) |-> o_ctrl == 8'h00 && !o_sda_oe && o_data_valid_n)
		else $error("reset values wrong");
	chk_oe_scl_low: assert property (
		$changed(o_sda_oe) |-> !i_scl) else $error("sda moved, scl high");
	chk_ctrl_at_ack: assert property (
		$changed(o_ctrl) |-> o_sda_oe) else $error("ctrl changed off ack");
	chk_pull_held: assert property (
		$rose(o_sda_oe) |-> o_sda_oe [*8]) else $error("pull too short");
	chk_mode_follows: assert property (
		$changed(o_teletext_label_mode) |-> o_sda_oe)
		else $error("mode moved off a write");
	chk_test_echo: assert property (
		(i_test_mode_pin && $stable(i_address_select_pin)) [*8] |->
		o_data_valid_n == i_address_select_pin &&
		o_first_field_flag == i_address_select_pin)
		else $error("test echo wrong");
	chk_field_flag: assert property (
		(!i_test_mode_pin && $stable(i_field_first)) [*8] |->
		o_first_field_flag == i_field_first) else $error("field flag wrong");

	cover property ($fell(o_data_valid_n));
	cover property ($changed(o_ctrl));
	cover property ($rose(o_sda_oe));

endmodule // vlcis_top_checker

bind vlcis_top vlcis_top_checker chk_i (
	.i_core_clk           (i_core_clk),
	.i_rst_n              (i_rst_n),
	.i_scl                (i_scl),
	.o_sda_out            (o_sda_out),
	.o_sda_oe             (o_sda_oe),
	.i_address_select_pin (i_address_select_pin),
	.i_test_mode_pin      (i_test_mode_pin),
	.i_field_first        (i_field_first),
	.o_data_valid_n       (o_data_valid_n),
	.o_first_field_flag   (o_first_field_flag),
	.o_teletext_label_mode(o_teletext_label_mode),
	.o_ctrl               (o_ctrl)
);

// ==== verification/vlcis_i2c_master_model.sv ====
/*
 * two-wire bus master standing in for the microcontroller.
 * assumes: i_sda is the wired level with a pull-up.
 */
`timescale 1ns/1ns

module vlcis_i2c_master_model (
	input  wire logic i_core_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	int hp = 4; // quarter bit in core cycles; raise to slow the bus

	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	task automatic wt(int n);
		repeat (n) @(posedge i_core_clk);
	endtask

	// ==================================================
	// bus conditions
	task automatic start();
		for (int n = 0; n < 64 && !i_sda; n++) wt(1);
		o_sda_low <= 1'b1;
		wt(2 * hp);
		o_scl <= 1'b0;
	endtask

	task automatic stop();
		wt(hp);
		o_sda_low <= 1'b1;
		wt(hp);
		o_scl <= 1'b1;
		wt(2 * hp);
		o_sda_low <= 1'b0;
		wt(2 * hp);
	endtask

	// sda moves only in the low half, so no false start or stop
	task automatic bit_io(logic b, output logic r);
		wt(hp);
		o_sda_low <= !b;
		wt(hp);
		o_scl <= 1'b1;
		wt(2 * hp);
		r = i_sda;
		o_scl <= 1'b0;
	endtask

	task automatic xbyte(logic [7:0] d, logic ab,
		output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ab, a);
	endtask

endmodule // vlcis_i2c_master_model

// ==== verification/test_vlcis_top.sv ====
/*
 * testbench for the label capture top: bus master, line source, pins.
 * assumes: package, design, checker and master model compiled first.
 */
`timescale 1ns/1ns

module test_vlcis_top;
	logic                   clk = 0;
	logic                   lclk = 0;
	logic                   rst_n = 0;
	vlcis_pkg::vlcis_line_t ln = '0;
	logic                   scl, sda_low, sda, oe, so, dv, ff, ttm;
	logic                   sel = 0, tst = 0, fld = 0;
	logic [7:0]             ctrl, cx = 8'h00, q;
	logic                   a;
	int                     err_count = 0, check_count = 0, cyc = 0;

	initial forever #2 clk = ~clk;
	initial forever begin #8 lclk = 1; #7 lclk = 0; end
	assign sda = !(sda_low || (oe && !so));

	vlcis_i2c_master_model mst (.i_core_clk(clk), .i_sda(sda),
		.o_scl(scl), .o_sda_low(sda_low));
	vlcis_top vlcis_top_i (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_line_clk(lclk), .i_line(ln), .i_scl(scl), .i_sda(sda),
		.o_sda_out(so), .o_sda_oe(oe), .i_address_select_pin(sel),
		.i_test_mode_pin(tst), .i_field_first(fld),
		.o_data_valid_n(dv), .o_first_field_flag(ff),
		.o_teletext_label_mode(ttm), .o_ctrl(ctrl));

	// ==================================================
	// checking and closing
	task automatic chk(logic [7:0] seen, logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			report_and_stop();
		end
	end

	// ==================================================
	// stimulus helpers
	function automatic logic [7:0] bv(int n);
		return 8'(n) ^ 8'hA5;
	endfunction

	function automatic logic [15:0] bip(logic [7:0] b);
		logic [15:0] w;
		for (int i = 0; i < 8; i++) w[2*i +: 2] = {b[i], !b[i]};
		return w;
	endfunction

	// odd parity per check group and over the whole byte
	function automatic logic [7:0] hm(logic [3:0] d);
		logic [7:0] b;
		b = {d[3], 1'b0, d[2], 1'b0, d[1], 1'b0, d[0], 1'b0};
		b[0] = !(b[1] ^ b[5] ^ b[7]);
		b[2] = !(b[1] ^ b[3] ^ b[7]);
		b[4] = !(b[1] ^ b[3] ^ b[5]);
		b[6] = !(^b);
		return b;
	endfunction

	function automatic logic [7:0] ex(vlcis_pkg::vlcis_kind_t k, int s);
		int n;
		case (k)
			vlcis_pkg::VLCIS_KIND_FMT2: return s > 6 ? 8'hFF :
				{4'(bv(13 + 2 * s)), s < 6 ? 4'(bv(14 + 2 * s)) : 4'hF};
			vlcis_pkg::VLCIS_KIND_FMT1: n = s < 7 ? s + 15 : s < 9 ? s + 6 : s + 13;
			vlcis_pkg::VLCIS_KIND_HDR:  n = s < 8 ? s + 38 : 0;
			default:                    n = s + 3;
		endcase
		return n ? bv(n) : 8'hFF;
	endfunction

	task automatic wait_dv(logic e);
		for (int n = 0; n < 400 && dv !== e; n++) @(posedge clk);
		chk({7'h0, dv}, {7'h0, e});
	endtask

	task automatic wr(logic [7:0] ad, logic [7:0] d, logic ak);
		mst.start();
		mst.xbyte(ad, 1'b1, q, a);
		chk({7'h0, a}, {7'h0, !ak});
		if (ak) begin
			mst.xbyte(d, 1'b1, q, a);
			cx = d;
		end
		mst.stop();
		chk(ctrl, cx);
		chk({7'h0, ttm}, {7'h0, cx[1]});
	endtask

	task automatic rd_all(vlcis_pkg::vlcis_kind_t k);
		mst.start();
		mst.xbyte(8'h21, 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
		for (int s = 0; s < 13; s++) begin
			mst.xbyte(8'hFF, s == 12, q, a);
			chk(q, ex(k, s));
		end
		mst.stop();
	endtask

	task automatic send_line(vlcis_pkg::vlcis_kind_t k, int nb, bit bad);
		logic [15:0] w;
		@(posedge lclk);
		ln.sof <= 1'b1;
		ln.kind <= k;
		for (int n = 1; n <= nb; n++) begin
			w = k == vlcis_pkg::VLCIS_KIND_L16 ? bip(bv(n)) : {8'h00, bv(n)};
			if (k == vlcis_pkg::VLCIS_KIND_FMT2) w[7:0] = hm(4'(bv(n)));
			// one single-bit fault that the decoder must repair
			if (k == vlcis_pkg::VLCIS_KIND_FMT2 && n == 14) w[3] = !w[3];
			if (bad && n == 5) w[0] = w[1];
			@(posedge lclk);
			ln.sof <= 1'b0;
			ln.word <= w;
			ln.word_valid <= 1'b1;
		end
		@(posedge lclk);
		ln.word_valid <= 1'b0;
		ln.eol <= 1'b1;
		@(posedge lclk);
		ln.eol <= 1'b0;
		repeat (10) @(posedge lclk);
	endtask

	// ==================================================
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (12) @(posedge clk);
		for (int e = 0; e < 4; e++) begin
			sel <= e[1];
			repeat (8) @(posedge clk);
			wr({6'h08, e[0], 1'b0}, 8'(e + 1), e[1] == e[0]);
		end
		sel <= 1'b0;
		wr(8'h20, 8'h03, 1'b1);
		send_line(vlcis_pkg::VLCIS_KIND_FMT1, 25, 0);
		wait_dv(1'b0);
		rd_all(vlcis_pkg::VLCIS_KIND_FMT1);
		mst.hp = 8;
		wr(8'h20, 8'h07, 1'b1);
		fld <= 1'b1;
		wait_dv(1'b1);
		chk({7'h0, ff}, 8'h01);
		send_line(vlcis_pkg::VLCIS_KIND_HDR, 45, 0);
		wait_dv(1'b0);
		rd_all(vlcis_pkg::VLCIS_KIND_HDR);
		mst.hp = 4;
		wr(8'h20, 8'h00, 1'b1);
		fld <= 1'b0;
		wait_dv(1'b1);
		send_line(vlcis_pkg::VLCIS_KIND_L16, 15, 1);
		repeat (100) @(posedge clk);
		chk({7'h0, dv}, 8'h01);
		// a line during a bus access is lost
		mst.start();
		mst.xbyte(8'h20, 1'b1, q, a);
		send_line(vlcis_pkg::VLCIS_KIND_L16, 15, 0);
		mst.xbyte(8'h00, 1'b1, q, a);
		mst.stop();
		repeat (100) @(posedge clk);
		chk({7'h0, dv}, 8'h01);
		send_line(vlcis_pkg::VLCIS_KIND_L16, 15, 0);
		wait_dv(1'b0);
		rd_all(vlcis_pkg::VLCIS_KIND_L16);
		wr(8'h20, 8'h02, 1'b1);
		fld <= 1'b1;
		wait_dv(1'b1);
		send_line(vlcis_pkg::VLCIS_KIND_FMT2, 25, 0);
		wait_dv(1'b0);
		rd_all(vlcis_pkg::VLCIS_KIND_FMT2);
		tst <= 1'b1;
		for (int v = 0; v < 2; v++) begin
			sel <= v[0];
			repeat (12) @(posedge clk);
			chk({6'h00, ff, dv}, {6'h00, v[0], v[0]});
		end
		tst <= 1'b0;
		report_and_stop();
	end

endmodule // test_vlcis_top
